//--- rtl/mif_pkg.sv
package mif_pkg;

   // Control-store locations of the microsteps that this block holds.
   localparam logic [8:0] LOC_RESERVED = 9'h001; // Reserved-instr entry.
   localparam logic [8:0] LOC_F1       = 9'h032;
   localparam logic [8:0] LOC_F2       = 9'h02B;
   localparam logic [8:0] LOC_F3       = 9'h0F5;
   localparam logic [8:0] LOC_F4       = 9'h0F4;
   localparam logic [8:0] LOC_F5       = 9'h031;
   localparam logic [8:0] LOC_S0_1     = 9'h081;
   localparam logic [8:0] LOC_S0_2     = 9'h007;
   localparam logic [8:0] LOC_S1_1     = 9'h083;
   localparam logic [8:0] LOC_S1_2     = 9'h0A4;
   localparam logic [8:0] LOC_S2_1     = 9'h085; // Source-mode2 entry.
   localparam logic [8:0] LOC_S2_2     = 9'h0C1;
   localparam logic [8:0] LOC_S2_3     = 9'h00C;
   localparam logic [8:0] LOC_S3_1     = 9'h087;
   localparam logic [8:0] LOC_S3_2     = 9'h08E;
   localparam logic [8:0] LOC_EX_OP    = 9'h002;
   localparam logic [8:0] LOC_EX_WR    = 9'h003;

   // Base decode offset of the double-operand source-mode dispatch.
   localparam logic [8:0] OFS_DOUBLE   = 9'h080;
   // Scratch-pad numbers of the program counter and of register 10.
   localparam logic [3:0] SP_PC        = 4'h7;
   localparam logic [3:0] SP_R10       = 4'h8;
   // Position of the sign bit copied by the sign-extend micro-order.
   localparam int         SEX_BIT      = 7;
   // Values after reset.
   localparam logic [8:0]  RST_MPC     = LOC_F1;
   localparam logic [15:0] RST_WORD    = 16'h0000;
   // Constants store location that the reserved routine loads.
   localparam logic [1:0]  K_VECTOR    = 2'h3;

   typedef enum logic [1:0] {RG_PC, RG_SRC, RG_DST, RG_R10} mif_reg_e;
   typedef enum logic [1:0] {BL_B, BL_TWO, BL_ONE_NB, BL_ZERO} mif_bleg_e;
   typedef enum logic [1:0] {FN_ADD, FN_ADD_CIN, FN_AUX, FN_PASS_A} mif_fn_e;
   typedef enum logic [1:0] {BD_NONE, BD_ALU, BD_BUS, BD_SEX} mif_bdst_e;
   typedef enum logic [1:0] {
      BC_NONE, BC_READ, BC_WRITE, BC_READ_PAUSE
   } mif_bus_e;
   typedef enum logic [2:0] {
      BT_NONE, BT_IR_DECODE, BT_INIT, BT_OVF_EN, BT_SLAVE_SYNC, BT_IR_CLOCK
   } mif_but_e;

   // One control-store word.
   typedef struct packed {
      logic [8:0] nxt;            // Next address field.
      mif_reg_e   reg_sel;        // Scratch-pad register named.
      logic       ba_ld;          // Load bus address register.
      logic       sp_wr;          // Write B into the named register.
      logic       a_konst;        // A-leg from the constants store.
      logic [1:0] k_idx;          // Constants store location.
      mif_bleg_e  bleg;           // ALU B-leg source.
      mif_fn_e    fn;             // ALU function.
      mif_bdst_e  b_dst;          // What loads the B-leg register.
      mif_bus_e   bus;            // Bus cycle started.
      logic       clock_off_bit;  // Hold until the transfer ends.
      logic       allow_byte_ref; // Permit an odd byte address.
      mif_but_e   branch_on_microtest;            // Branch on microtest code.
   } mif_word_s;

   // An idle word that simply returns to the fetch routine.
   localparam mif_word_s MW_IDLE = '{
      nxt: LOC_F1, reg_sel: RG_PC, ba_ld: 1'b0, sp_wr: 1'b0,
      a_konst: 1'b0, k_idx: 2'h0, bleg: BL_ZERO, fn: FN_PASS_A,
      b_dst: BD_NONE, bus: BC_NONE, clock_off_bit: 1'b0,
      allow_byte_ref: 1'b0, branch_on_microtest: BT_NONE};

   // True for a byte form of a double-operand instruction.
   function automatic logic mif_is_byte(input logic [15:0] ir);
      mif_is_byte = ir[15] & (ir[14:12] != 3'h0) & (ir[14:12] != 3'h7);
   endfunction

   // Constants store: locations 0 to 2 hold their own number, location 3 holds four.
   function automatic logic [15:0] mif_konst(input logic [1:0] idx);
      case (idx)
         2'h0:    mif_konst = 16'h0000;
         2'h1:    mif_konst = 16'h0001;
         2'h2:    mif_konst = 16'h0002;
         default: mif_konst = 16'h0004;
      endcase
   endfunction

endpackage

//--- rtl/mif_alu.sv
`timescale 1ns/1ps
// Data-path ALU with the auxiliary control and the instruction decode.
module mif_alu
   import mif_pkg::*;
(
   input  wire logic [15:0]      i_ir,
   input  wire logic [15:0]      i_a_leg,
   input  wire logic [15:0]      i_b_leg,
   input  wire mif_pkg::mif_fn_e i_fn,
   output logic [15:0]           o_result,
   output logic [8:0]            o_dispatch
);

   logic [2:0] op; // Double-operand opcode field.

   // Auxiliary control picks the operation from the held instruction.
   always_comb begin
      op = i_ir[14:12];
      case (i_fn)
         FN_ADD:     o_result = i_a_leg + i_b_leg;
         FN_ADD_CIN: o_result = i_a_leg + i_b_leg + 16'h0001;
         FN_PASS_A:  o_result = i_a_leg;
         default: begin
            case (op)
               3'h1:    o_result = i_b_leg;
               3'h2:    o_result = i_a_leg - i_b_leg;
               3'h3:    o_result = i_a_leg & i_b_leg;
               3'h4:    o_result = ~i_a_leg & i_b_leg;
               3'h5:    o_result = i_a_leg | i_b_leg;
               default: o_result = i_a_leg + i_b_leg;
            endcase
         end
      endcase
   end

   // Decode only double operands with source modes 0 to 3; anything
   // else offers no bits, which lands on the reserved routine.
   always_comb begin
      if ((op != 3'h0) && (op != 3'h7) && !i_ir[11]) begin
         o_dispatch = OFS_DOUBLE | {6'h00, i_ir[10:9], 1'b0};
      end else begin
         o_dispatch = 9'h000;
      end
   end

endmodule

//--- rtl/mif_spad.sv
`timescale 1ns/1ps
// Sixteen-word scratch-pad whose read and write share one address port.
module mif_spad
   import mif_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic [3:0]  i_addr,
   input  wire logic        i_we,
   input  wire logic [15:0] i_wdata,
   output logic [15:0]      o_rdata
);

   // All storage lives in one struct so it resets as a whole.
   typedef struct packed {
      logic [15:0][15:0] regs; // Scratch-pad words.
   } mif_spad_s;

   mif_spad_s st_q;
   mif_spad_s st_d;

   // Read is combinational so a step sees its register in the same cycle.
   assign o_rdata = st_q.regs[i_addr];

   // Write the addressed word.
   always_comb begin
      st_d = st_q;
      if (i_we) begin
         st_d.regs[i_addr] = i_wdata;
      end
   end

   // Registers clear on reset; software never relies on them otherwise.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

endmodule

//--- rtl/mif_sequencer.sv
`timescale 1ns/1ps
// What this block does
// - Sign-extend copies B bit 7 upward.
// - Source register comes from IR 8:6.
// - Destination register comes from IR 2:0.
// - Register-10 op B chosen from IR.
// - Constant operand enters on A-leg.
// - Jump puts target in next-address field.
// - Working tests do control actions instead.
// - Read, write, read-pause cycles use BA.
// - F-1 loads BA from PC, reads.
// - F-2 loads B with PC plus two.
// - F-3 writes PC, holds until read done.
// - F-4 loads read data into B, IR.
// - F-5 sign-extends and branches on decode.
// - Unrecognised instruction goes to location one.
// - Decode offset is ORed into next address.
// - Odd address without byte permit errors.
// - Autoincrement adds one for bytes, else two.
module mif_sequencer
   import mif_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic [15:0] i_bus_rdata,
   input  wire logic        i_bus_done,
   output logic [15:0]      o_bus_addr,
   output logic [15:0]      o_bus_wdata,
   output logic             o_bus_read,
   output logic             o_bus_write,
   output logic             o_bus_read_pause,
   output logic             o_bus_error,
   output logic [8:0]       o_mpc,
   output logic [15:0]      o_ir,
   output logic [15:0]      o_b_leg,
   output logic             o_clock_off,
   output logic             o_stack_ovf_en,
   output logic             o_slave_sync,
   output logic             o_init
);

   // Whole state of the sequencer.
   typedef struct packed {
      logic [8:0]  micro_program_counter;           // Micro-program counter.
      logic [15:0] ir;            // Instruction register.
      logic [15:0] b_leg;         // B-leg register.
      logic [15:0] ba;            // Bus address register.
      logic [15:0] wdata;         // Data offered with a write.
      logic [15:0] rdata;         // Last word returned by the bus.
      logic        pending;       // A bus transfer is outstanding.
      logic        clock_off_bit; // Microstep clocking is held.
      logic        rd;            // Read cycle start pulse.
      logic        wr;            // Write cycle start pulse.
      logic        rp;            // Read-pause cycle start pulse.
      logic        bus_err;       // Bus error pulse.
      logic        init;          // Initialise pulse.
      logic        slave_sync;    // Slave sync pulse.
      logic        ovf_en;        // Stack overflow detection enabled.
   } mif_seq_s;

   localparam mif_seq_s SEQ_RST = '{micro_program_counter: RST_MPC, default: '0};

   mif_seq_s    st_q;       // Registered state.
   mif_seq_s    st_d;       // Next state.
   mif_word_s   mw;         // Word at the current location.
   logic        step;       // The current microstep executes.
   logic        byte_instr; // The IR holds a byte instruction.
   logic [3:0]  sp_addr;    // Scratch-pad register named by the step.
   logic [15:0] sp_rdata;   // Contents of that register.
   logic [15:0] a_leg;      // ALU A-leg.
   logic [15:0] b_src;      // ALU B-leg.
   logic [15:0] alu_out;    // ALU result.
   logic [8:0]  dispatch;   // Decode offset for the dispatch.
   logic [15:0] bus_addr;   // Address that a new cycle would use.
   logic        odd_bad;    // A new cycle would fault.

   // Control store; locations not held here fall back to the fetch.
   function automatic mif_word_s cstore(input logic [8:0] loc);
      mif_word_s w;
      w = MW_IDLE;
      case (loc)
         LOC_F1: begin
            w.nxt = LOC_F2;
            w.ba_ld = 1'b1;
            w.bus = BC_READ;
         end
         LOC_F2: begin
            w.nxt = LOC_F3;
            w.bleg = BL_TWO;
            w.fn = FN_ADD;
            w.b_dst = BD_ALU;
         end
         LOC_F3: begin
            w.nxt = LOC_F4;
            w.sp_wr = 1'b1;
            w.clock_off_bit = 1'b1;
         end
         LOC_F4: begin
            w.nxt = LOC_F5;
            w.b_dst = BD_BUS;
            w.branch_on_microtest = BT_IR_CLOCK;
         end
         LOC_F5: begin
            w.nxt = LOC_RESERVED;
            w.b_dst = BD_SEX;
            w.branch_on_microtest = BT_IR_DECODE;
         end
         LOC_RESERVED: begin
            w.a_konst = 1'b1;
            w.k_idx = K_VECTOR;
            w.b_dst = BD_ALU;
            w.branch_on_microtest = BT_INIT;
         end
         LOC_S0_1: begin
            w.nxt = LOC_S0_2;
            w.reg_sel = RG_SRC;
            w.b_dst = BD_ALU;
         end
         LOC_S0_2: begin
            w.nxt = LOC_EX_OP;
            w.reg_sel = RG_R10;
            w.sp_wr = 1'b1;
         end
         LOC_EX_OP: begin
            w.nxt = LOC_EX_WR;
            w.reg_sel = RG_R10;
            w.bleg = BL_B;
            w.fn = FN_AUX;
            w.b_dst = BD_ALU;
            w.branch_on_microtest = BT_OVF_EN;
         end
         LOC_EX_WR: begin
            w.reg_sel = RG_DST;
            w.ba_ld = 1'b1;
            w.bus = BC_WRITE;
            w.clock_off_bit = 1'b1;
            w.branch_on_microtest = BT_SLAVE_SYNC;
         end
         LOC_S1_1: begin
            w.nxt = LOC_S1_2;
            w.reg_sel = RG_SRC;
            w.ba_ld = 1'b1;
            w.bus = BC_READ;
            w.clock_off_bit = 1'b1;
            w.allow_byte_ref = 1'b1;
         end
         LOC_S1_2: begin
            w.nxt = LOC_S0_2;
            w.b_dst = BD_BUS;
         end
         LOC_S2_1: begin
            w.nxt = LOC_S2_2;
            w.reg_sel = RG_SRC;
            w.ba_ld = 1'b1;
            w.bus = BC_READ;
            w.allow_byte_ref = 1'b1;
         end
         LOC_S2_2: begin
            w.nxt = LOC_S2_3;
            w.reg_sel = RG_SRC;
            w.bleg = BL_ONE_NB;
            w.fn = FN_ADD_CIN;
            w.b_dst = BD_ALU;
         end
         LOC_S2_3: begin
            w.nxt = LOC_S1_2;
            w.reg_sel = RG_SRC;
            w.sp_wr = 1'b1;
            w.clock_off_bit = 1'b1;
         end
         LOC_S3_1: begin
            w.nxt = LOC_S3_2;
            w.reg_sel = RG_SRC;
            w.ba_ld = 1'b1;
            w.bus = BC_READ_PAUSE;
         end
         LOC_S3_2: begin
            w.nxt = LOC_S2_3;
            w.reg_sel = RG_SRC;
            w.bleg = BL_TWO;
            w.fn = FN_ADD;
            w.b_dst = BD_ALU;
         end
         default: begin
            w = MW_IDLE;
         end
      endcase
      return w;
   endfunction

   // Operand selection for the scratch-pad and both ALU legs.
   always_comb begin
      mw = cstore(st_q.micro_program_counter);
      step = ~st_q.clock_off_bit;
      byte_instr = mif_is_byte(st_q.ir);
      case (mw.reg_sel)
         RG_PC:   sp_addr = SP_PC;
         RG_SRC:  sp_addr = {1'b0, st_q.ir[8:6]};
         RG_DST:  sp_addr = {1'b0, st_q.ir[2:0]};
         default: sp_addr = SP_R10;
      endcase
      // The constants store drives the A-leg in place of a register.
      a_leg = mw.a_konst ? mif_konst(mw.k_idx) : sp_rdata;
      case (mw.bleg)
         BL_B:      b_src = st_q.b_leg;
         BL_TWO:    b_src = 16'h0002;
         BL_ONE_NB: b_src = byte_instr ? 16'h0000 : 16'h0001;
         default:   b_src = 16'h0000;
      endcase
      // A step that loads BA and starts a cycle uses the new address.
      bus_addr = mw.ba_ld ? sp_rdata : st_q.ba;
      odd_bad = bus_addr[0] & ~(mw.allow_byte_ref & byte_instr);
   end

   mif_alu u_alu (
      .i_ir       (st_q.ir),
      .i_a_leg    (a_leg),
      .i_b_leg    (b_src),
      .i_fn       (mw.fn),
      .o_result   (alu_out),
      .o_dispatch (dispatch)
   );

   mif_spad u_spad (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_addr  (sp_addr),
      .i_we    (step & mw.sp_wr),
      .i_wdata (st_q.b_leg),
      .o_rdata (sp_rdata)
   );

   // Step execution, bus bookkeeping and next-address formation.
   always_comb begin
      st_d = st_q;
      st_d.rd = 1'b0;
      st_d.wr = 1'b0;
      st_d.rp = 1'b0;
      st_d.bus_err = 1'b0;
      st_d.init = 1'b0;
      st_d.slave_sync = 1'b0;
      // Completion clears the hold on the next edge; the held step runs on the edge after that.
      if (st_q.pending && i_bus_done) begin
         st_d.rdata = i_bus_rdata;
         st_d.pending = 1'b0;
         st_d.clock_off_bit = 1'b0;
      end
      if (step) begin
         if (mw.ba_ld) begin
            st_d.ba = sp_rdata;
         end
         case (mw.b_dst)
            BD_ALU:  st_d.b_leg = alu_out;
            BD_BUS:  st_d.b_leg = st_q.rdata;
            BD_SEX:  st_d.b_leg = {{8{st_q.b_leg[SEX_BIT]}},
                                   st_q.b_leg[7:0]};
            default: st_d.b_leg = st_q.b_leg;
         endcase
         // An odd address is refused outright, so no cycle is pending.
         if (mw.bus != BC_NONE) begin
            if (odd_bad) begin
               st_d.bus_err = 1'b1;
            end else begin
               st_d.pending = 1'b1;
               st_d.wdata = st_q.b_leg;
               st_d.rd = (mw.bus == BC_READ);
               st_d.wr = (mw.bus == BC_WRITE);
               st_d.rp = (mw.bus == BC_READ_PAUSE);
            end
         end
         // Holding only matters while a transfer is still outstanding.
         st_d.clock_off_bit = mw.clock_off_bit & st_d.pending;
         case (mw.branch_on_microtest)
            BT_IR_CLOCK:   st_d.ir = st_q.rdata;
            BT_INIT: begin
               st_d.init = 1'b1;
               st_d.ovf_en = 1'b0;
            end
            BT_OVF_EN:     st_d.ovf_en = 1'b1;
            BT_SLAVE_SYNC: st_d.slave_sync = 1'b1;
            default:       st_d.ovf_en = st_q.ovf_en;
         endcase
         // Decode bits are wire-ORed into the next-address field.
         st_d.micro_program_counter = mw.nxt
            | ((mw.branch_on_microtest == BT_IR_DECODE) ? dispatch : 9'h000);
      end
   end

   // State register.
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_q <= SEQ_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_bus_addr       = st_q.ba;
   assign o_bus_wdata      = st_q.wdata;
   assign o_bus_read       = st_q.rd;
   assign o_bus_write      = st_q.wr;
   assign o_bus_read_pause = st_q.rp;
   assign o_bus_error      = st_q.bus_err;
   assign o_mpc            = st_q.micro_program_counter;
   assign o_ir             = st_q.ir;
   assign o_b_leg          = st_q.b_leg;
   assign o_clock_off      = st_q.clock_off_bit;
   assign o_stack_ovf_en   = st_q.ovf_en;
   assign o_slave_sync     = st_q.slave_sync;
   assign o_init           = st_q.init;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   // A microstep at a given location that actually executes.
   sequence s_step(logic [8:0] loc);
      step && (st_q.micro_program_counter == loc);
   endsequence

   // A clock-off stall, in the fetch or any other step: held, then released by completion.
   sequence s_release;
      st_q.clock_off_bit && i_bus_done;
   endsequence

   a_fetch_read: assert property (
      s_step(LOC_F1) |=> o_bus_read && (o_bus_addr == $past(sp_rdata)))
      else $error("fetch did not read at the program counter");
   a_fetch_incr: assert property (
      s_step(LOC_F2) |=> o_b_leg == $past(sp_rdata) + 16'h0002)
      else $error("program counter plus two not loaded");
   a_clock_hold: assert property (
      st_q.clock_off_bit && !i_bus_done |=> $stable(st_q.micro_program_counter))
      else $error("microstep ran while clock off");
   a_clock_resume: assert property (
      s_release |=> !o_clock_off ##1 (o_mpc != $past(o_mpc)))
      else $error("clock off not cleared on completion");
   a_ir_load: assert property (
      s_step(LOC_F4) |=> (o_ir == $past(st_q.rdata))
                         && (o_b_leg == $past(st_q.rdata)))
      else $error("instruction load wrong");
   a_sign_fill: assert property (
      s_step(LOC_F5) |=> (o_b_leg[15:8] == {8{$past(st_q.b_leg[7])}})
                         && (o_b_leg[7:0] == $past(st_q.b_leg[7:0])))
      else $error("sign extend wrong");
   a_decode_or: assert property (
      s_step(LOC_F5) |=> o_mpc == (LOC_RESERVED | $past(dispatch)))
      else $error("dispatch address wrong");
   a_next_addr: assert property (
      step && (mw.branch_on_microtest != BT_IR_DECODE) |=> o_mpc == $past(mw.nxt))
      else $error("next address not latched");
   a_odd_error: assert property (
      step && (mw.bus != BC_NONE) && odd_bad
      |=> o_bus_error && !o_bus_read && !o_bus_write && !o_bus_read_pause)
      else $error("odd address not refused");
   a_auto_incr: assert property (
      s_step(LOC_S2_2) |=> o_b_leg == $past(sp_rdata)
         + ($past(byte_instr) ? 16'h0001 : 16'h0002))
      else $error("autoincrement step wrong");

endmodule

//--- tb/mif_bus_mem.sv
`timescale 1ns/1ps
// Word memory on the far side of the bus; answers each start pulse.
module mif_bus_mem (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_start,
   input  wire logic [15:0] i_addr,
   input  wire logic        i_slow,
   output logic             o_done,
   output logic [15:0]      o_rdata
);
   logic [15:0] mem [0:15]; // Contents, loaded by the bench.
   logic [15:0] addr_q;     // Address of the pending transfer.
   int          wait_q;     // Cycles to the answer, zero when idle.
   initial begin
      o_done = 1'b0;
      o_rdata = 16'h5A5A;
      wait_q = 0;
   end
   // Data toggles when not answering, so a stale read cannot pass.
   // Each branch gives the done pulse its value once, so no edge ever
   // carries two writes to it.
   always @(posedge i_clock) begin
      if (i_rst) begin
         o_done <= 1'b0;
         wait_q <= 0;
         o_rdata <= ~o_rdata;
      end else if (i_start) begin
         o_done <= 1'b0;
         addr_q <= i_addr;
         wait_q <= i_slow ? 6 : 1;
         o_rdata <= ~o_rdata;
      end else if (wait_q == 1) begin
         o_done <= 1'b1;
         o_rdata <= mem[addr_q[4:1]];
         wait_q <= 0;
      end else begin
         o_done <= 1'b0;
         o_rdata <= ~o_rdata;
         if (wait_q > 1) begin
            wait_q <= wait_q - 1;
         end
      end
   end
endmodule

//--- tb/microcoded_instruction_fetch_test.sv
`timescale 1ns/1ps
// Fetches a table of instructions and checks each step of the fetch.
module microcoded_instruction_fetch_test;
   import mif_pkg::*;
   typedef struct packed {
      logic [15:0] ins;  // Instruction word in memory.
      logic [8:0]  disp; // Microstep expected after decode.
   } mif_row_s;
   localparam int NR = 13;
   // Odd rows answer slowly so that the clock-off hold is exercised.
   mif_row_s rows [NR] = '{
      '{16'h0000, LOC_RESERVED}, '{16'h1000, LOC_S0_1},
      '{16'h1200, LOC_S1_1}, '{16'h1400, LOC_S2_1},
      '{16'h1600, LOC_S3_1}, '{16'h2480, LOC_S2_1},
      '{16'h6A7F, LOC_RESERVED}, '{16'h7000, LOC_RESERVED},
      '{16'h9000, LOC_S0_1}, '{16'h9440, LOC_S2_1},
      '{16'h1240, LOC_S1_1}, '{16'h9240, LOC_S1_1},
      '{16'h0000, LOC_RESERVED}};
   logic        i_clock = 1'b0;
   logic        i_rst = 1'b1;
   logic        slow = 1'b0;
   logic [15:0] bus_rdata;
   logic        bus_done;
   logic [15:0] bus_addr;
   logic [15:0] wdata;
   logic        rd, wr, rp, berr, cko, ovf, sync, init;
   logic        start;
   logic [8:0]  micro_program_counter;
   logic [15:0] ir, bleg;
   int          n_errors = 0;
   int          checks = 0;
   int          n_init = 0, n_sync = 0, n_berr = 0, n_pause = 0;
   int          e_init = 0, e_sync = 0;

   assign start = rd | wr | rp;
   always #10 i_clock = ~i_clock;

   mif_sequencer i_mif_sequencer (
      .i_clock(i_clock), .i_rst(i_rst), .i_bus_rdata(bus_rdata),
      .i_bus_done(bus_done), .o_bus_addr(bus_addr), .o_bus_wdata(wdata),
      .o_bus_read(rd), .o_bus_write(wr), .o_bus_read_pause(rp),
      .o_bus_error(berr), .o_mpc(micro_program_counter), .o_ir(ir), .o_b_leg(bleg),
      .o_clock_off(cko), .o_stack_ovf_en(ovf), .o_slave_sync(sync),
      .o_init(init));
   mif_bus_mem i_mif_bus_mem (
      .i_clock(i_clock), .i_rst(i_rst), .i_start(start),
      .i_addr(bus_addr), .i_slow(slow), .o_done(bus_done),
      .o_rdata(bus_rdata));

   // Pulse counters for the control actions, read-pause cycles and refused transfers.
   always @(posedge i_clock) begin
      if (!i_rst) begin
         n_init += (init === 1'b1);
         n_sync += (sync === 1'b1);
         n_berr += (berr === 1'b1);
         n_pause += (rp === 1'b1);
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Follows one fetch; the counter n bounds every wait.
   task automatic fetch(input int k);
      int          n;
      logic [15:0] w;
      n = 0;
      w = rows[k].ins;
      @(negedge i_clock);
      while (!(rd === 1'b1 && micro_program_counter === LOC_F2) && n < 80) begin
         @(negedge i_clock);
         n++;
      end
      chk(bus_addr, 16'(2 * k));
      @(negedge i_clock);
      chk(bleg, 16'(2 * k + 2));
      chk({7'h00, micro_program_counter}, {7'h00, LOC_F3});
      if (k[0]) begin
         while (bus_done !== 1'b1 && n < 80) begin
            @(negedge i_clock);
            n++;
         end
         chk({15'h0000, cko}, 16'h0001);
         @(negedge i_clock);
         chk({15'h0000, cko}, 16'h0000);
      end
      while (micro_program_counter !== LOC_F5 && n < 80) begin
         @(negedge i_clock);
         n++;
      end
      chk(ir, w);
      chk(bleg, w);
      @(negedge i_clock);
      chk(bleg, {{8{w[7]}}, w[7:0]});
      chk({7'h00, micro_program_counter}, {7'h00, rows[k].disp});
      chk({15'h0000, n >= 80}, 16'h0000);
      // The reserved step loads the constant four; the last row stops
      // short of it so that the enable checked afterwards survives.
      if (rows[k].disp == LOC_RESERVED && k < NR - 1) begin
         @(negedge i_clock);
         chk(bleg, 16'h0004);
         chk({15'h0000, init}, 16'h0001);
      end
   endtask

   // Waits for the next write pulse and checks its address and data.
   task automatic wait_write(input logic [15:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge i_clock);
      while (wr !== 1'b1 && n < 80) begin
         @(negedge i_clock);
         n++;
      end
      chk({15'h0000, n >= 80}, 16'h0000);
      chk(bus_addr, a);
      chk(wdata, d);
   endtask

   // Cuts a hang short well after the expected run of about 300 cycles.
   initial begin
      #50000;
      n_errors++;
      summarize;
   end

   initial begin
      for (int k = 0; k < NR; k++) begin
         i_mif_bus_mem.mem[k] = rows[k].ins;
      end
      repeat (19) @(posedge i_clock);
      @(negedge i_clock);
      chk({7'h00, micro_program_counter}, {7'h00, RST_MPC});
      chk(ir, RST_WORD);
      chk({12'h000, rd, wr, cko, init}, 16'h0000);
      @(posedge i_clock);
      i_rst <= 1'b0;
      for (int k = 0; k < NR; k++) begin
         @(posedge i_clock);
         slow <= k[0];
         fetch(k);
         if (k < NR - 1) begin
            e_init += (rows[k].disp == LOC_RESERVED);
            e_sync += (rows[k].disp != LOC_RESERVED);
         end
      end
      // R1 becomes odd by a byte increment, so only the word read refuses.
      chk(16'(n_berr), 16'h0001);
      chk(16'(n_pause), 16'h0001);
      chk(16'(n_init), 16'(e_init));
      chk(16'(n_sync), 16'(e_sync));
      chk({15'h0000, ovf}, 16'h0001);
      // Reset in mid-run must bring back the fetch entry and clear all.
      @(posedge i_clock);
      i_rst <= 1'b1;
      // Compare and add, both autoincrement from R1 with R1 as target.
      i_mif_bus_mem.mem[0] = 16'h2441;
      i_mif_bus_mem.mem[1] = 16'h6441;
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      chk({7'h00, micro_program_counter}, {7'h00, RST_MPC});
      chk(ir, RST_WORD);
      chk(bleg, RST_WORD);
      chk({8'h00, rd, wr, rp, berr, cko, ovf, sync, init}, 16'h0000);
      @(posedge i_clock);
      i_rst <= 1'b0;
      // The operand equals R10, so subtract gives zero and add doubles.
      wait_write(16'h0002, 16'h0000);
      wait_write(16'h0004, 16'hC882);
      summarize;
   end
endmodule
